// ===== logic/flow_flag_pkg.sv
// constants and types shared by the flow and flag instruction unit
package flow_flag_pkg;

    // opcodes
    localparam logic [7:0] OP_NOP = 8'h01;
    localparam logic [7:0] OP_TO_FLAGS = 8'h06;
    localparam logic [7:0] OP_TO_ACC = 8'h07;
    localparam logic [7:0] OP_CLR_V = 8'h0a;
    localparam logic [7:0] OP_SET_V = 8'h0b;
    localparam logic [7:0] OP_CLR_C = 8'h0c;
    localparam logic [7:0] OP_SET_C = 8'h0d;
    localparam logic [7:0] OP_CLR_I = 8'h0e;
    localparam logic [7:0] OP_SET_I = 8'h0f;
    localparam logic [7:0] OP_SLEEP = 8'h1a;
    localparam logic [7:0] OP_RET_SUB = 8'h39;
    localparam logic [7:0] OP_RET_INT = 8'h3b;
    localparam logic [7:0] OP_WAIT = 8'h3e;
    localparam logic [7:0] OP_TRAP = 8'h3f;
    localparam logic [7:0] OP_CALL_DIR = 8'h9d;

    // flag bit positions
    localparam int FLAG_H = 5;
    localparam int FLAG_I = 4;
    localparam int FLAG_N = 3;
    localparam int FLAG_Z = 2;
    localparam int FLAG_V = 1;
    localparam int FLAG_C = 0;

    // reset values
    localparam logic [7:0] FLAGS_RESET = 8'hd0;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [15:0] PC_RESET = 16'h0000;

    // machine cycle counts per instruction
    localparam logic [3:0] CYC_ONE = 4'h1;
    localparam logic [3:0] CYC_RET_SUB = 4'h5;
    localparam logic [3:0] CYC_CALL = 4'h5;
    localparam logic [3:0] CYC_RET_INT = 4'ha;
    localparam logic [3:0] CYC_WAIT = 4'h9;
    localparam logic [3:0] CYC_TRAP = 4'hc;

    // program bytes
    localparam logic [15:0] LEN_ONE = 16'h0001;
    localparam logic [15:0] LEN_TWO = 16'h0002;

    // bus idle value while waiting
    localparam logic [15:0] WAIT_ADDR = 16'hffff;

    typedef enum logic [1:0] {
        ST_FETCH = 2'b00,
        ST_EXEC = 2'b01,
        ST_WAIT = 2'b11,
        ST_SLEEP = 2'b10
    } cpu_state_t;

endpackage

// ===== logic/cycle_timer.sv
// down counter that times the machine cycles of one instruction
`timescale 1ns/1ps
module cycle_timer (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // control
    input wire logic load_i,
    input wire logic [3:0] count_i,
    // status
    output logic done_o
);
    import flow_flag_pkg::*;

    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        if (load_i) begin
            cnt_nxt = count_i;
        end else if (cnt_r != 4'h0) begin
            cnt_nxt = cnt_r - 4'h1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cnt_r <= 4'h0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // last cycle of the loaded count
    assign done_o = (cnt_r == 4'h1);
endmodule

// ===== logic/flow_flag_unit.sv
// flow control and flag manipulation instruction unit
//
// Function
// - during wait, read/write high, address all ones, data bus released.
// - wait opcode 3e, one byte, nine cycles before waiting.
// - trap opcode 3f, one byte, twelve cycles, sets interrupt mask.
// - interrupt return is one byte and takes ten cycles.
// - subroutine return opcode 39, one byte, five cycles, flags kept.
// - no-operation opcode 01, one byte, one cycle, only advances counter.
// - direct subroutine call is two bytes, five cycles, flags kept.
// - carry clear writes zero to carry in one cycle.
// - mask clear writes zero to interrupt mask in one cycle.
// - overflow clear writes zero to overflow in one cycle.
// - mask set writes one to interrupt mask in one cycle.
// - overflow set writes one to overflow in one cycle.
// - opcode 06 copies accumulator a into all flags.
// - opcode 07 copies flags into accumulator a, flags kept.
// - interrupt return reloads every flag from stacked value.
// - wait sets mask on interrupt; masked wait ends only by nmi.
`timescale 1ns/1ps
module flow_flag_unit (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // instruction stream
    input wire logic op_valid_i,
    input wire logic [7:0] opcode_i,
    output logic op_ready_o,
    output logic op_done_o,
    // stacked flags for interrupt return
    input wire logic [7:0] stacked_flags_i,
    // interrupt requests, synchronous to ref_clk_i
    input wire logic irq_i,
    input wire logic nmi_i,
    // accumulator a load
    input wire logic acc_load_i,
    input wire logic [7:0] acc_load_data_i,
    output logic [7:0] acc_a_o,
    // condition flags
    output logic [7:0] condition_flags_o,
    // program counter
    output logic [15:0] pc_o,
    // bus
    output logic rw_o,
    output logic [15:0] addr_o,
    output logic data_oe_o,
    // status
    output logic waiting_o,
    output logic sleeping_o,
    output logic irq_taken_o
);
    import flow_flag_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    cpu_state_t state_r, state_nxt;
    logic [7:0] op_r, op_nxt;
    logic [7:0] flags_r, flags_nxt;
    logic [7:0] acc_r, acc_nxt;
    logic [15:0] pc_r, pc_nxt;
    logic taken_r, taken_nxt;
    logic [15:0] addr_r, addr_nxt;
    logic timer_load;
    logic [3:0] timer_count;
    logic timer_done;

    // cycles per opcode, used only to load the cycle timer
    function automatic logic [3:0] op_cycles(input logic [7:0] op);
        case (op)
            OP_RET_SUB: op_cycles = CYC_RET_SUB;
            OP_CALL_DIR: op_cycles = CYC_CALL;
            OP_RET_INT: op_cycles = CYC_RET_INT;
            OP_WAIT: op_cycles = CYC_WAIT;
            OP_TRAP: op_cycles = CYC_TRAP;
            default: op_cycles = CYC_ONE;
        endcase
    endfunction

    function automatic logic [15:0] op_length(input logic [7:0] op);
        op_length = (op == OP_CALL_DIR) ? LEN_TWO : LEN_ONE;
    endfunction

    cycle_timer u_timer (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .load_i(timer_load),
        .count_i(timer_count),
        .done_o(timer_done)
    );

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        op_nxt = op_r;
        flags_nxt = flags_r;
        acc_nxt = acc_r;
        pc_nxt = pc_r;
        taken_nxt = 1'b0;
        timer_load = 1'b0;
        timer_count = op_cycles(opcode_i);
        if (acc_load_i) begin
            acc_nxt = acc_load_data_i;
        end
        unique case (state_r)
            ST_FETCH: begin
                if (op_valid_i) begin
                    op_nxt = opcode_i;
                    timer_load = 1'b1;
                    state_nxt = ST_EXEC;
                end
            end
            ST_EXEC: begin
                if (timer_done) begin
                    state_nxt = ST_FETCH;
                    pc_nxt = pc_r + op_length(op_r);
                    unique case (op_r)
                        OP_CLR_C: flags_nxt[FLAG_C] = 1'b0;
                        OP_SET_C: flags_nxt[FLAG_C] = 1'b1;
                        OP_CLR_I: flags_nxt[FLAG_I] = 1'b0;
                        OP_SET_I: flags_nxt[FLAG_I] = 1'b1;
                        OP_CLR_V: flags_nxt[FLAG_V] = 1'b0;
                        OP_SET_V: flags_nxt[FLAG_V] = 1'b1;
                        // accumulator to flags; bits 7:6 always read one
                        OP_TO_FLAGS: flags_nxt = {2'b11, acc_r[5:0]};
                        OP_TO_ACC: acc_nxt = flags_r;
                        OP_RET_INT: flags_nxt = {2'b11, stacked_flags_i[5:0]};
                        OP_TRAP: flags_nxt[FLAG_I] = 1'b1;
                        OP_WAIT: state_nxt = ST_WAIT;
                        OP_SLEEP: state_nxt = ST_SLEEP;
                        default: flags_nxt = flags_r;
                    endcase
                end
            end
            ST_WAIT: begin
                // masked wait leaves only on nmi
                if (nmi_i || (irq_i && !flags_r[FLAG_I])) begin
                    flags_nxt[FLAG_I] = 1'b1;
                    taken_nxt = 1'b1;
                    state_nxt = ST_FETCH;
                end
            end
            ST_SLEEP: begin
                if (nmi_i || irq_i) begin
                    taken_nxt = 1'b1;
                    state_nxt = ST_FETCH;
                end
            end
        endcase
        addr_nxt = (state_nxt == ST_WAIT) ? WAIT_ADDR : pc_nxt;
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_r <= ST_FETCH;
            op_r <= OP_NOP;
            flags_r <= FLAGS_RESET;
            acc_r <= ACC_RESET;
            pc_r <= PC_RESET;
            taken_r <= 1'b0;
            addr_r <= PC_RESET;
        end else begin
            state_r <= state_nxt;
            op_r <= op_nxt;
            flags_r <= flags_nxt;
            acc_r <= acc_nxt;
            pc_r <= pc_nxt;
            taken_r <= taken_nxt;
            addr_r <= addr_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign op_ready_o = (state_r == ST_FETCH);
    assign op_done_o = (state_r == ST_EXEC) && timer_done;
    assign acc_a_o = acc_r;
    assign condition_flags_o = flags_r;
    assign pc_o = pc_r;
    assign rw_o = 1'b1;
    assign addr_o = addr_r;
    // data bus never driven by this unit; stores live elsewhere
    assign data_oe_o = 1'b0;
    assign waiting_o = (state_r == ST_WAIT);
    assign sleeping_o = (state_r == ST_SLEEP);
    assign irq_taken_o = taken_r;
endmodule

// ===== verification/flow_flag_unit_asserts.sv
// checker for the flow and flag unit
`timescale 1ns/1ps
module flow_flag_unit_asserts
    import flow_flag_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // watched ports
    input wire logic op_valid_i,
    input wire logic [7:0] opcode_i,
    input wire logic op_ready_o,
    input wire logic op_done_o,
    input wire logic [7:0] stacked_flags_i,
    input wire logic [7:0] condition_flags_o,
    input wire logic [15:0] pc_o,
    input wire logic rw_o,
    input wire logic [15:0] addr_o,
    input wire logic data_oe_o,
    input wire logic waiting_o,
    input wire logic irq_taken_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    logic go;
    assign go = op_ready_o && op_valid_i;
    AST_WAIT_BUS: assert property (waiting_o |-> addr_o == WAIT_ADDR && rw_o && !data_oe_o)
        else $error("bus not parked in wait");
    AST_WAIT_LEN: assert property (go && opcode_i == OP_WAIT
        |=> !op_done_o [*8] ##1 op_done_o) else $error("wait length wrong");
    AST_TRAP: assert property (go && opcode_i == OP_TRAP
        |-> ##12 op_done_o ##1 condition_flags_o[FLAG_I]) else $error("trap wrong");
    AST_RET_INT: assert property (go && opcode_i == OP_RET_INT
        |-> ##10 op_done_o ##1 condition_flags_o[5:0] == $past(stacked_flags_i[5:0]))
        else $error("interrupt return wrong");
    AST_RET_SUB: assert property (go && opcode_i == OP_RET_SUB
        |-> ##5 op_done_o ##1 condition_flags_o == $past(condition_flags_o, 6))
        else $error("subroutine return wrong");
    AST_NOP: assert property (go && opcode_i == OP_NOP
        |=> op_done_o ##1 pc_o == $past(pc_o, 2) + 16'h0001) else $error("no-op wrong");
    AST_CLR_C: assert property (go && opcode_i == OP_CLR_C
        |=> op_done_o ##1 condition_flags_o == ($past(condition_flags_o, 2) & 8'hfe))
        else $error("carry clear wrong");
    AST_WAKE_I: assert property (irq_taken_o && $past(waiting_o) |-> condition_flags_o[FLAG_I])
        else $error("mask not set on wake");
    cover property (go && opcode_i == OP_WAIT);
    cover property (go && opcode_i == OP_RET_INT);
    cover property (irq_taken_o);
endmodule
bind flow_flag_unit flow_flag_unit_asserts chk_u (.*);

// ===== verification/ext_bus_model.sv
// far side: interrupt sources and the stacked flag byte
`timescale 1ns/1ps
module ext_bus_model #(parameter logic [7:0] STACKED = 8'h25) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // requests from the bench and wake from the unit
    input wire logic irq_req_i,
    input wire logic nmi_req_i,
    input wire logic irq_taken_i,
    // towards the unit
    output logic [7:0] stacked_flags_o,
    output logic irq_o,
    output logic nmi_o
);
    // a request stays up until taken, as a real source would
    always_ff @(posedge ref_clk_i) begin
        irq_o <= !(rst_i || irq_taken_i) && (irq_o || irq_req_i);
        nmi_o <= !(rst_i || irq_taken_i) && (nmi_o || nmi_req_i);
    end
    assign stacked_flags_o = STACKED;
endmodule

// ===== verification/cpu_flow_and_flag_instructions_tb.sv
// self-checking bench for the flow and flag unit
`timescale 1ns/1ps
module cpu_flow_and_flag_instructions_tb;
    import flow_flag_pkg::*;
    logic ref_clk_i = 1'b0, rst_i = 1'b1, op_valid_i = 1'b0, acc_load_i = 1'b0;
    logic irq_req = 1'b0, nmi_req = 1'b0, irq_i, nmi_i, op_ready_o, op_done_o, rw_o;
    logic data_oe_o, waiting_o, sleeping_o, irq_taken_o;
    logic [7:0] opcode_i = 8'h01, acc_load_data_i = 8'h2a;
    logic [7:0] stacked_flags_i, acc_a_o, condition_flags_o;
    logic [15:0] pc_o, addr_o, pc0;
    int failures = 0, n_checks = 0, cycles = 0, n, n_taken = 0;
    always #20 ref_clk_i = ~ref_clk_i;
    flow_flag_unit dut_u (.*);
    ext_bus_model far_u (.ref_clk_i, .rst_i, .irq_req_i(irq_req), .nmi_req_i(nmi_req),
        .irq_taken_i(irq_taken_o), .stacked_flags_o(stacked_flags_i), .irq_o(irq_i), .nmi_o(nmi_i));
    task automatic ck(input string what, input logic [15:0] seen, input logic [15:0] xp);
        n_checks++;
        if (seen !== xp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, xp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // one opcode through the handshake; n ends as its cycle count
    task automatic run_op(input logic [7:0] op);
        op_valid_i <= 1'b1;
        opcode_i <= op;
        do @(posedge ref_clk_i); while (op_ready_o !== 1'b1);
        op_valid_i <= 1'b0;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (op_done_o !== 1'b1 && n < 20);
        // results land on the done edge, so look one edge later
        @(posedge ref_clk_i);
    endtask
    task automatic raise(input logic by_nmi);
        irq_req <= !by_nmi;
        nmi_req <= by_nmi;
        @(posedge ref_clk_i);
        irq_req <= 1'b0;
        nmi_req <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_flags();
        logic [7:0] ops[7] = '{OP_TO_FLAGS, OP_SET_C, OP_SET_I, OP_CLR_V, OP_SET_V, OP_CLR_I, OP_CLR_C};
        logic [7:0] xf[7] = '{8'hea, 8'heb, 8'hfb, 8'hf9, 8'hfb, 8'heb, 8'hea};
        acc_load_i <= 1'b1;
        @(posedge ref_clk_i);
        acc_load_i <= 1'b0;
        foreach (ops[i]) begin
            run_op(ops[i]);
            ck("flags", condition_flags_o, xf[i]);
            ck("one cycle", n, 1);
        end
        run_op(OP_TO_ACC);
        ck("acc", acc_a_o, 8'hea);
        ck("kept", condition_flags_o, 8'hea);
    endtask
    task automatic t_flow();
        run_op(OP_RET_SUB);
        ck("ret sub", n, 5);
        ck("ret sub flags", condition_flags_o, 8'hea);
        pc0 = pc_o;
        run_op(OP_NOP);
        ck("nop", n, 1);
        ck("nop pc", pc_o, pc0 + 16'h0001);
        run_op(OP_CALL_DIR);
        ck("call", n, 5);
        ck("call pc", pc_o, pc0 + 16'h0003);
        ck("call flags", condition_flags_o, 8'hea);
        run_op(OP_RET_INT);
        ck("ret int", n, 10);
        ck("ret int flags", condition_flags_o, 8'he5);
        run_op(OP_TRAP);
        ck("trap", n, 12);
        ck("trap flags", condition_flags_o, 8'hf5);
    endtask
    task automatic t_wait();
        run_op(OP_CLR_I);
        run_op(OP_WAIT);
        ck("wait", n, 9);
        ck("wait bus", {rw_o, data_oe_o, waiting_o}, 3'b101);
        ck("wait addr", addr_o, WAIT_ADDR);
        raise(1'b0);
        ck("irq wake", {waiting_o, condition_flags_o[FLAG_I]}, 2'b01);
        run_op(OP_SLEEP);
        ck("asleep", sleeping_o, 1'b1);
        raise(1'b0);
        ck("sleep wake", sleeping_o, 1'b0);
        // mask now set: a plain request must not end the wait
        run_op(OP_WAIT);
        raise(1'b0);
        ck("masked", waiting_o, 1'b1);
        raise(1'b1);
        ck("nmi wake", waiting_o, 1'b0);
        // one pulse per wake: irq, sleep and nmi
        ck("wake pulses", n_taken, 3);
    endtask
    initial begin
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
        ck("reset flags", condition_flags_o, FLAGS_RESET);
        t_flags();
        t_flow();
        t_wait();
        tally_and_finish();
    end
    // hang guard, well above the roughly 120 cycles the run needs
    always @(posedge ref_clk_i) begin
        cycles++;
        if (irq_taken_o === 1'b1) n_taken++;
        if (cycles == 2000) begin
            failures++;
            tally_and_finish();
        end
    end
endmodule
